// >>> dmau_defs.svh
`ifndef DMAU_DEFS_SVH
`define DMAU_DEFS_SVH

// Register addresses inside the data space
`define DMAU_BANK_ADDR 12'hFF0
`define DMAU_FLAGS_ADDR 12'hFF1
`define DMAU_PTR_BASE 12'hFC0

// Offsets inside one pointer group of eight addresses
`define DMAU_OFF_PLAIN 3'h0
`define DMAU_OFF_AFTER_ACCESS_DOWN_PORT 3'h1
`define DMAU_OFF_AFTER_ACCESS_UP_PORT 3'h2
`define DMAU_OFF_BEFORE_ACCESS_UP_PORT 3'h3
`define DMAU_OFF_INDEXED 3'h4
`define DMAU_OFF_LO 3'h5
`define DMAU_OFF_HI 3'h6

// Common access-bank split
`define DMAU_ACC_SPLIT 8'h80
`define DMAU_ACC_LOW_BANK 4'h0
`define DMAU_ACC_HIGH_BANK 4'hF

// Flag positions
`define DMAU_FLAG_N 4
`define DMAU_FLAG_OV 3
`define DMAU_FLAG_Z 2
`define DMAU_FLAG_DC 1
`define DMAU_FLAG_C 0

// Reset values and default implemented-bank mask
`define DMAU_BANK_RST 8'h00
`define DMAU_FLAGS_RST 8'h00
`define DMAU_PTR_RST 12'h000
`define DMAU_IMPL_MASK 16'h8001

`endif

// >>> dmau_pkg.sv
package dmau_pkg;
  typedef enum logic [1:0] {
    ADJ_NONE = 2'h0,
    ADJ_INC = 2'h1,
    ADJ_DEC = 2'h3
  } dmau_adj_t;

  typedef enum logic [2:0] {
    ALU_NONE = 3'h0,
    ALU_ADD = 3'h1,
    ALU_SUB = 3'h3,
    ALU_LOGIC = 3'h2,
    ALU_ROTL = 3'h6,
    ALU_ROTR = 3'h7
  } dmau_alu_t;
endpackage

// >>> dmau_ptr_if.sv
`timescale 1ns/10ps
interface dmau_ptr_if import dmau_pkg::*; #(parameter int AW = 12);
  logic wr_lo;
  logic wr_hi;
  logic [7:0] wdata;
  dmau_adj_t adj;
  logic [AW-1:0] value;
  modport ctrl (output wr_lo, wr_hi, wdata, adj, input value);
  modport ptr (input wr_lo, wr_hi, wdata, adj, output value);
endinterface

// >>> dmau_ptr.sv
`timescale 1ns/10ps
`include "dmau_defs.svh"
module dmau_ptr import dmau_pkg::*; #(parameter int AW = 12) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Control from the address unit
  dmau_ptr_if.ptr pif
);
  logic [AW-1:0] value_ff;

  // Byte writes win over any adjustment; adjust wraps modulo the space
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      value_ff <= AW'(`DMAU_PTR_RST);
    end else if (pif.wr_lo) begin
      value_ff[7:0] <= pif.wdata; // RULE6 RULE13
    end else if (pif.wr_hi) begin
      value_ff[AW-1:8] <= pif.wdata[AW-9:0]; // RULE6 RULE13
    end else if (pif.adj == ADJ_INC) begin
      value_ff <= value_ff + AW'(1); // RULE12 RULE22
    end else if (pif.adj == ADJ_DEC) begin
      value_ff <= value_ff - AW'(1); // RULE12 RULE22
    end
  end

  assign pif.value = value_ff;

  ////////////////////////////////////////////////////////////////////////
  ptr_inc_a: assert property (@(posedge clock_i) disable iff (rst_i) // RULE12
    (pif.adj == ADJ_INC && !pif.wr_lo && !pif.wr_hi) |=>
      value_ff == AW'($past(value_ff) + AW'(1)))
    else $error("pointer increment wrong");
  ptr_dec_a: assert property (@(posedge clock_i) disable iff (rst_i) // RULE22
    (pif.adj == ADJ_DEC && !pif.wr_lo && !pif.wr_hi && value_ff == '0) |=>
      value_ff == {AW{1'b1}})
    else $error("pointer decrement does not wrap");
  ptr_hold_a: assert property (@(posedge clock_i) disable iff (rst_i) // RULE13
    pif.wr_lo |=>
      value_ff[AW-1:8] == $past(value_ff[AW-1:8]) && value_ff[7:0] == $past(pif.wdata))
    else $error("pointer adjusted during byte write");
endmodule

// >>> dmau_top.sv
`timescale 1ns/10ps
`include "dmau_defs.svh"
// Notes on behaviour
// (RULE1) Direct access: bank register low nibble forms address bits 11:8.
// (RULE2) Bank register upper nibble reads zero, writes to it ignored.
// (RULE3) Unimplemented bank: reads give zero, writes dropped, flags still update.
// (RULE4) Access bit clear: bank register ignored, common access bank used.
// (RULE5) Full-address move takes whole 12-bit address, ignores bank register.
// (RULE6) Three 12-bit pointers, each a high and a low byte register.
// (RULE7) Indirect port access goes to the pointed address; port stores nothing.
// (RULE8) Pointer at a port: read gives zero and sets zero flag; write is nop.
// (RULE9) Five ports per pointer: plain, post-down, post-up, pre-up, indexed.
// (RULE10) Indexed port adds sign-extended accumulator; pointer and accumulator unchanged.
// (RULE11) Pointer adjustment never touches any flag.
// (RULE12) Pointer adjustment spans all twelve bits with carry and borrow.
// (RULE13) Indirect write to a pointer byte stores it and skips adjustment.
// (RULE14) Flags as destination of flag-affecting op: result dropped, flags updated.
// (RULE15) Software should alter flags only with bit, swap and move operations.
// (RULE16) Negative flag, bit 4, is result bit 7.
// (RULE17) Signed wrap flag, bit 3, set on two's complement overflow.
// (RULE18) Zero flag, bit 2, set when result is zero, else cleared.
// (RULE19) Nibble carry flag, bit 1, is carry out of bit 3 on add/sub.
// (RULE20) Carry flag, bit 0, is carry out of bit 7 on add/sub.
// (RULE21) Subtract adds two's complement; rotates load carry with bit shifted out.
// (RULE22) Pointer adjustment wraps modulo 4096 silently.
module dmau_top import dmau_pkg::*; #(
  parameter logic [15:0] IMPL_MASK = `DMAU_IMPL_MASK
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Data access from the decoder
  input wire logic op_valid_i,
  input wire logic op_write_i,
  input wire logic [7:0] op_file_i,
  input wire logic op_access_i,
  input wire logic op_full_i,
  input wire logic [11:0] op_full_addr_i,
  input wire logic [7:0] op_wdata_i,
  input wire logic [7:0] working_accumulator_i,
  // Bank literal load
  input wire logic bank_literal_load_i,
  input wire logic [7:0] bank_lit_i,
  // Flag update from the execution datapath
  input wire logic alu_valid_i,
  input wire dmau_alu_t alu_kind_i,
  input wire logic [7:0] alu_a_i,
  input wire logic [7:0] alu_b_i,
  // Data memory port
  output logic [11:0] ram_addr_o,
  output logic ram_re_o,
  output logic ram_we_o,
  output logic [7:0] ram_wdata_o,
  // Read answer from local registers or forced zero
  output logic rd_local_o,
  output logic [7:0] rd_data_o,
  // Register views
  output logic [7:0] bank_select_reg_o,
  output logic [7:0] alu_flags_o
);
  localparam logic [11:0] PTR_BASE = `DMAU_PTR_BASE;
  localparam int NPTR = 3;

  logic [7:0] bank_select_ff;
  logic [7:0] alu_flags_ff;
  logic [11:0] ptr_val [NPTR];
  logic [NPTR-1:0] ptr_wr_lo;
  logic [NPTR-1:0] ptr_wr_hi;
  dmau_adj_t ptr_adj [NPTR];
  logic [11:0] eff_addr;
  logic [11:0] fin_addr;
  logic [11:0] ind_base;
  logic [11:0] ind_target;
  logic [1:0] ind_sel;
  logic [2:0] ind_mode;
  logic ind_hit;
  logic tgt_port;
  logic bank_ok;
  logic is_wr;
  logic is_rd;
  logic hit_bank;
  logic hit_flags;
  logic hit_ptr;
  logic own_hit;
  logic port_nop;
  logic alu_live;
  logic [7:0] own_rdata;
  logic [7:0] alu_res;
  logic [7:0] nxt_alu_flags;
  logic [7:0] alu_opb;
  logic alu_cin;
  logic [8:0] alu_sum;
  logic [4:0] alu_nib;

  function automatic logic is_port(input logic [11:0] a);
    return a[11:5] == PTR_BASE[11:5] && a[4:3] != 2'h3 && a[2:0] <= `DMAU_OFF_INDEXED;
  endfunction

  function automatic logic is_ptr_byte(input logic [11:0] a);
    return a[11:5] == PTR_BASE[11:5] && a[4:3] != 2'h3 &&
      (a[2:0] == `DMAU_OFF_LO || a[2:0] == `DMAU_OFF_HI);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pointers
  for (genvar n = 0; n < NPTR; n++) begin : g_ptr
    dmau_ptr_if #(.AW(12)) pif ();
    dmau_ptr #(.AW(12)) u_ptr (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .pif(pif)
    );
    assign pif.wr_lo = ptr_wr_lo[n];
    assign pif.wr_hi = ptr_wr_hi[n];
    assign pif.wdata = op_wdata_i;
    assign pif.adj = ptr_adj[n];
    assign ptr_val[n] = pif.value;
  end

  ////////////////////////////////////////////////////////////////////////
  // Address formation
  always_comb begin
    eff_addr = {bank_select_ff[3:0], op_file_i}; // RULE1
    if (op_full_i) begin
      eff_addr = op_full_addr_i; // RULE5
    end else if (!op_access_i) begin
      eff_addr = (op_file_i < `DMAU_ACC_SPLIT) ? {`DMAU_ACC_LOW_BANK, op_file_i}
                                               : {`DMAU_ACC_HIGH_BANK, op_file_i}; // RULE4
    end
  end

  assign ind_hit = op_valid_i && is_port(eff_addr);
  assign ind_sel = eff_addr[4:3];
  assign ind_mode = eff_addr[2:0];
  assign ind_base = ptr_val[ind_sel];

  always_comb begin
    case (ind_mode)
      `DMAU_OFF_BEFORE_ACCESS_UP_PORT: ind_target = ind_base + 12'h001; // RULE9
      `DMAU_OFF_INDEXED: ind_target = ind_base +
        {{4{working_accumulator_i[7]}}, working_accumulator_i}; // RULE10
      default: ind_target = ind_base;
    endcase
  end

  assign fin_addr = ind_hit ? ind_target : eff_addr; // RULE7
  assign tgt_port = ind_hit && is_port(ind_target); // RULE8
  assign bank_ok = IMPL_MASK[fin_addr[11:8]]; // RULE3
  assign is_wr = op_valid_i && op_write_i;
  assign is_rd = op_valid_i && !op_write_i;
  assign hit_bank = fin_addr == `DMAU_BANK_ADDR;
  assign hit_flags = fin_addr == `DMAU_FLAGS_ADDR;
  assign hit_ptr = is_ptr_byte(fin_addr);
  assign own_hit = hit_bank || hit_flags || hit_ptr;
  assign port_nop = is_wr && tgt_port; // RULE8
  assign alu_live = alu_valid_i && alu_kind_i != ALU_NONE && !port_nop;

  always_comb begin
    for (int n = 0; n < NPTR; n++) begin
      ptr_wr_lo[n] = is_wr && hit_ptr && fin_addr[4:3] == 2'(n) &&
        fin_addr[2:0] == `DMAU_OFF_LO; // RULE6
      ptr_wr_hi[n] = is_wr && hit_ptr && fin_addr[4:3] == 2'(n) &&
        fin_addr[2:0] == `DMAU_OFF_HI; // RULE6
      ptr_adj[n] = ADJ_NONE;
      if (ind_hit && ind_sel == 2'(n) && !port_nop && !(is_wr && hit_ptr)) begin // RULE13
        case (ind_mode)
          `DMAU_OFF_AFTER_ACCESS_DOWN_PORT: ptr_adj[n] = ADJ_DEC; // RULE9
          `DMAU_OFF_AFTER_ACCESS_UP_PORT: ptr_adj[n] = ADJ_INC; // RULE9
          `DMAU_OFF_BEFORE_ACCESS_UP_PORT: ptr_adj[n] = ADJ_INC; // RULE9
          default: ptr_adj[n] = ADJ_NONE;
        endcase
      end
    end
  end

  always_comb begin
    own_rdata = 8'h00;
    if (hit_bank) begin
      own_rdata = bank_select_ff;
    end else if (hit_flags) begin
      own_rdata = alu_flags_ff;
    end else if (hit_ptr) begin
      own_rdata = (fin_addr[2:0] == `DMAU_OFF_LO) ? ptr_val[fin_addr[4:3]][7:0]
                                                 : {4'h0, ptr_val[fin_addr[4:3]][11:8]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flag calculation
  always_comb begin
    alu_opb = (alu_kind_i == ALU_SUB) ? ~alu_b_i : alu_b_i; // RULE21
    alu_cin = alu_kind_i == ALU_SUB;
    alu_sum = {1'b0, alu_a_i} + {1'b0, alu_opb} + {8'h00, alu_cin};
    alu_nib = {1'b0, alu_a_i[3:0]} + {1'b0, alu_opb[3:0]} + {4'h0, alu_cin};
    nxt_alu_flags = alu_flags_ff;
    alu_res = alu_a_i;
    case (alu_kind_i)
      ALU_ADD, ALU_SUB: begin
        alu_res = alu_sum[7:0];
        nxt_alu_flags[`DMAU_FLAG_C] = alu_sum[8]; // RULE20
        nxt_alu_flags[`DMAU_FLAG_DC] = alu_nib[4]; // RULE19
        nxt_alu_flags[`DMAU_FLAG_OV] = (alu_a_i[7] == alu_opb[7]) &&
          (alu_sum[7] != alu_a_i[7]); // RULE17
      end
      ALU_ROTL: begin
        alu_res = {alu_a_i[6:0], alu_flags_ff[`DMAU_FLAG_C]};
        nxt_alu_flags[`DMAU_FLAG_C] = alu_a_i[7]; // RULE21
      end
      ALU_ROTR: begin
        alu_res = {alu_flags_ff[`DMAU_FLAG_C], alu_a_i[7:1]};
        nxt_alu_flags[`DMAU_FLAG_C] = alu_a_i[0]; // RULE21
      end
      default: alu_res = alu_a_i;
    endcase
    nxt_alu_flags[`DMAU_FLAG_Z] = alu_res == 8'h00; // RULE18
    nxt_alu_flags[`DMAU_FLAG_N] = alu_res[7]; // RULE16
    nxt_alu_flags[7:5] = 3'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      alu_flags_ff <= `DMAU_FLAGS_RST;
    end else if (alu_live) begin
      alu_flags_ff <= nxt_alu_flags; // RULE14 RULE3 RULE11
    end else if (is_rd && tgt_port) begin
      alu_flags_ff[`DMAU_FLAG_Z] <= 1'b1; // RULE8
    end else if (is_wr && hit_flags) begin
      alu_flags_ff <= {3'h0, op_wdata_i[4:0]};
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bank_select_ff <= `DMAU_BANK_RST;
    end else if (bank_literal_load_i) begin
      bank_select_ff <= {4'h0, bank_lit_i[3:0]}; // RULE2
    end else if (is_wr && hit_bank) begin
      bank_select_ff <= {4'h0, op_wdata_i[3:0]}; // RULE2
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ram_addr_o <= 12'h000;
      ram_re_o <= 1'b0;
      ram_we_o <= 1'b0;
      ram_wdata_o <= 8'h00;
      rd_local_o <= 1'b0;
      rd_data_o <= 8'h00;
    end else begin
      ram_addr_o <= fin_addr;
      ram_re_o <= is_rd && !own_hit && bank_ok && !tgt_port; // RULE3
      ram_we_o <= is_wr && !own_hit && bank_ok && !tgt_port; // RULE3 RULE8
      ram_wdata_o <= op_wdata_i;
      rd_local_o <= is_rd && (own_hit || !bank_ok || tgt_port);
      rd_data_o <= (is_rd && own_hit && !tgt_port) ? own_rdata : 8'h00; // RULE3 RULE8
    end
  end

  assign bank_select_reg_o = bank_select_ff;
  assign alu_flags_o = alu_flags_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  bank_upper_zero_a: assert property (bank_select_reg_o[7:4] == 4'h0) // RULE2
    else $error("bank upper nibble not zero");
  direct_addr_a: assert property ( // RULE1
    (op_valid_i && !op_full_i && op_access_i && !is_port(eff_addr)) |=>
      ram_addr_o == {$past(bank_select_ff[3:0]), $past(op_file_i)})
    else $error("direct address wrong");
  access_bank_a: assert property ( // RULE4
    (op_valid_i && !op_full_i && !op_access_i && op_file_i < 8'h80) |=>
      ram_addr_o[11:8] == 4'h0)
    else $error("access bank low region wrong");
  full_addr_a: assert property ( // RULE5
    (op_valid_i && op_full_i && !is_port(op_full_addr_i)) |=>
      ram_addr_o == $past(op_full_addr_i))
    else $error("full address not used");
  unimpl_zero_a: assert property ( // RULE3
    (is_rd && !bank_ok && !own_hit) |=> rd_local_o && rd_data_o == 8'h00 && !ram_re_o)
    else $error("unimplemented bank read not zero");
  port_nop_a: assert property ( // RULE8
    port_nop |=> !ram_we_o && $stable(alu_flags_o))
    else $error("port write not a nop");
  port_read_a: assert property ( // RULE8
    (is_rd && tgt_port && !alu_live) |=> alu_flags_o[2] && rd_data_o == 8'h00)
    else $error("port read did not give zero");
  indexed_keep_a: assert property ( // RULE10
    (ind_hit && ind_mode == `DMAU_OFF_INDEXED && !is_wr) |=>
      ptr_val[$past(ind_sel)] == $past(ind_base))
    else $error("indexed access changed pointer");
  zero_neg_a: assert property ( // RULE18
    (alu_live && alu_kind_i == ALU_ADD) |=>
      alu_flags_o[2] == ($past(8'(alu_a_i + alu_b_i)) == 8'h00) &&
      alu_flags_o[4] == $past(8'(alu_a_i + alu_b_i) >= 8'h80))
    else $error("zero or negative flag wrong");
  carry_sub_a: assert property ( // RULE21
    (alu_live && alu_kind_i == ALU_SUB) |=>
      alu_flags_o[0] == ($past(alu_a_i) >= $past(alu_b_i)))
    else $error("borrow polarity wrong");

  after_access_up_port_c: cover property (ind_hit && ind_mode == `DMAU_OFF_AFTER_ACCESS_UP_PORT ##1 ram_re_o);
  bank_load_c: cover property (bank_literal_load_i ##1 bank_select_reg_o != 8'h00);
  flags_dest_c: cover property (is_wr && hit_flags && alu_live);
  unimpl_c: cover property (is_wr && !bank_ok);
endmodule

// >>> dmau_ram_model.sv
`timescale 1ns/10ps
module dmau_ram_model (
  // Clock
  input wire logic clock_i,
  // Memory port from the address unit
  input wire logic [11:0] ram_addr_i,
  input wire logic ram_we_i,
  input wire logic [7:0] ram_wdata_i,
  // Inspection port
  input wire logic [11:0] peek_addr_i,
  output logic [7:0] peek_data_o
);
  logic [7:0] mem_ff [4096];
  // Redirected writes land at the pointed location
  always_ff @(posedge clock_i) begin
    if (ram_we_i) begin
      mem_ff[ram_addr_i] <= ram_wdata_i;
    end
  end
  assign peek_data_o = mem_ff[peek_addr_i];
endmodule

// >>> data_memory_addressing_unit_bench.sv
`timescale 1ns/10ps
module data_memory_addressing_unit_bench;
  import dmau_pkg::*;
  logic clock_i, rst_i, op_valid_i, op_write_i, op_access_i, op_full_i;
  logic [7:0] op_file_i, op_wdata_i, working_accumulator_i, bank_lit_i, alu_a_i, alu_b_i;
  logic [11:0] op_full_addr_i, ram_addr_o, peek_addr;
  logic bank_literal_load_i, alu_valid_i, ram_re_o, ram_we_o, rd_local_o;
  dmau_alu_t alu_kind_i;
  logic [7:0] ram_wdata_o, rd_data_o, bank_select_reg_o, alu_flags_o, peek_data;
  int fail_count = 0;
  int compares = 0;
  ////////////////////////////////////////////////////////////////////////////////
  dmau_top #(.IMPL_MASK(16'hFFF7)) u_dut (.clock_i(clock_i), .rst_i(rst_i),
    .op_valid_i(op_valid_i), .op_write_i(op_write_i), .op_file_i(op_file_i),
    .op_access_i(op_access_i), .op_full_i(op_full_i), .op_full_addr_i(op_full_addr_i),
    .op_wdata_i(op_wdata_i), .working_accumulator_i(working_accumulator_i),
    .bank_literal_load_i(bank_literal_load_i), .bank_lit_i(bank_lit_i),
    .alu_valid_i(alu_valid_i), .alu_kind_i(alu_kind_i), .alu_a_i(alu_a_i),
    .alu_b_i(alu_b_i), .ram_addr_o(ram_addr_o), .ram_re_o(ram_re_o), .ram_we_o(ram_we_o),
    .ram_wdata_o(ram_wdata_o), .rd_local_o(rd_local_o), .rd_data_o(rd_data_o),
    .bank_select_reg_o(bank_select_reg_o), .alu_flags_o(alu_flags_o));
  dmau_ram_model u_ram (.clock_i(clock_i), .ram_addr_i(ram_addr_o), .ram_we_i(ram_we_o),
    .ram_wdata_i(ram_wdata_o), .peek_addr_i(peek_addr), .peek_data_o(peek_data));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // One request cycle after an idle edge; outputs are settled on return
  task automatic cyc(input logic ov, input logic wr, input logic acc, input logic [7:0] f,
      input logic [7:0] d, input logic av, input dmau_alu_t k, input logic [7:0] a,
      input logic [7:0] b, input logic bl);
    @(posedge clock_i);
    #1;
    op_valid_i = ov;
    op_write_i = wr;
    op_access_i = acc;
    op_file_i = f;
    op_wdata_i = d;
    alu_valid_i = av;
    alu_kind_i = k;
    alu_a_i = a;
    alu_b_i = b;
    bank_literal_load_i = bl;
    bank_lit_i = d;
    @(posedge clock_i);
    #1;
    op_valid_i = 1'b0;
    alu_valid_i = 1'b0;
    bank_literal_load_i = 1'b0;
  endtask
  task automatic op(input logic wr, input logic acc, input logic [7:0] f, input logic [7:0] d);
    cyc(1'b1, wr, acc, f, d, 1'b0, ALU_NONE, 8'h00, 8'h00, 1'b0);
  endtask
  task automatic rd(input logic acc, input logic [7:0] f, input logic [11:0] exp);
    op(1'b0, acc, f, 8'h00);
    chk("read strobe", 12'h001, {11'h000, ram_re_o});
    chk("address", exp, ram_addr_o);
  endtask
  task automatic flg(input dmau_alu_t k, input logic [7:0] a, input logic [7:0] b,
      input logic [7:0] m, input logic [7:0] exp);
    cyc(1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b1, k, a, b, 1'b0);
    chk("flags", {4'h0, exp}, {4'h0, alu_flags_o & m});
  endtask
  task automatic local_zero();
    chk("local answer", 12'h001, {11'h000, rd_local_o});
    chk("local data", 12'h000, {4'h0, rd_data_o});
    chk("read strobe", 12'h000, {11'h000, ram_re_o});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  initial begin
    #(20 * 2000);
    fail_count++;
    end_of_test();
  end
  initial begin
    rst_i = 1'b1;
    op_valid_i = 1'b0;
    op_write_i = 1'b0;
    op_access_i = 1'b0;
    op_full_i = 1'b0;
    op_file_i = 8'h00;
    op_wdata_i = 8'h00;
    op_full_addr_i = 12'h000;
    working_accumulator_i = 8'h00;
    bank_literal_load_i = 1'b0;
    bank_lit_i = 8'h00;
    alu_valid_i = 1'b0;
    alu_kind_i = ALU_NONE;
    alu_a_i = 8'h00;
    alu_b_i = 8'h00;
    peek_addr = 12'h255;
    repeat (2) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    chk("bank", 12'h000, {4'h0, bank_select_reg_o});
    chk("flags", 12'h000, {4'h0, alu_flags_o});
    cyc(1'b0, 1'b0, 1'b0, 8'h00, 8'hA5, 1'b0, ALU_NONE, 8'h00, 8'h00, 1'b1);
    chk("bank", 12'h005, {4'h0, bank_select_reg_o});
    op(1'b1, 1'b0, 8'hF0, 8'hFF);
    chk("bank", 12'h00F, {4'h0, bank_select_reg_o});
    op(1'b0, 1'b0, 8'hF0, 8'h00);
    chk("bank read", 12'h00F, {4'h0, rd_data_o});
    $display("test bank register done");
    cyc(1'b0, 1'b0, 1'b0, 8'h00, 8'h02, 1'b0, ALU_NONE, 8'h00, 8'h00, 1'b1);
    rd(1'b1, 8'h34, 12'h234);
    rd(1'b0, 8'h10, 12'h010);
    rd(1'b0, 8'h90, 12'hF90);
    op_full_i = 1'b1;
    op_full_addr_i = 12'h2AB;
    rd(1'b1, 8'h00, 12'h2AB);
    op_full_i = 1'b0;
    op(1'b1, 1'b1, 8'h55, 8'h3C);
    chk("write strobe", 12'h001, {11'h000, ram_we_o});
    chk("write data", 12'h03C, {4'h0, ram_wdata_o});
    @(posedge clock_i);
    #1;
    chk("memory", 12'h03C, {4'h0, peek_data});
    cyc(1'b0, 1'b0, 1'b0, 8'h00, 8'h03, 1'b0, ALU_NONE, 8'h00, 8'h00, 1'b1);
    op(1'b0, 1'b1, 8'h20, 8'h00);
    local_zero();
    cyc(1'b1, 1'b1, 1'b1, 8'h20, 8'h77, 1'b1, ALU_ADD, 8'h7F, 8'h01, 1'b0);
    chk("write strobe", 12'h000, {11'h000, ram_we_o});
    chk("flags", 12'h01A, {4'h0, alu_flags_o});
    $display("test direct addressing done");
    op(1'b1, 1'b0, 8'hC5, 8'hFF);
    op(1'b1, 1'b0, 8'hC6, 8'h00);
    rd(1'b0, 8'hC2, 12'h0FF);
    rd(1'b0, 8'hC0, 12'h100);
    rd(1'b0, 8'hC1, 12'h100);
    rd(1'b0, 8'hC0, 12'h0FF);
    rd(1'b0, 8'hC3, 12'h100);
    working_accumulator_i = 8'h80;
    rd(1'b0, 8'hC4, 12'h080);
    working_accumulator_i = 8'h7F;
    rd(1'b0, 8'hC4, 12'h17F);
    rd(1'b0, 8'hC0, 12'h100);
    op(1'b1, 1'b0, 8'hC6, 8'h0F);
    op(1'b1, 1'b0, 8'hC5, 8'hFF);
    rd(1'b0, 8'hC2, 12'hFFF);
    rd(1'b0, 8'hC0, 12'h000);
    rd(1'b0, 8'hC1, 12'h000);
    rd(1'b0, 8'hC0, 12'hFFF);
    chk("flags", 12'h01A, {4'h0, alu_flags_o});
    op(1'b0, 1'b0, 8'hC6, 8'h00);
    chk("pointer high", 12'h00F, {4'h0, rd_data_o});
    $display("test pointers done");
    op(1'b1, 1'b0, 8'hCD, 8'hC0);
    op(1'b1, 1'b0, 8'hCE, 8'h0F);
    op(1'b0, 1'b0, 8'hC8, 8'h00);
    local_zero();
    chk("flags", 12'h01E, {4'h0, alu_flags_o});
    flg(ALU_ADD, 8'h01, 8'h01, 8'h1F, 8'h00);
    cyc(1'b1, 1'b1, 1'b0, 8'hC8, 8'h55, 1'b1, ALU_ADD, 8'h00, 8'h00, 1'b0);
    chk("write strobe", 12'h000, {11'h000, ram_we_o});
    chk("flags", 12'h000, {4'h0, alu_flags_o});
    op(1'b1, 1'b0, 8'hD5, 8'hD5);
    op(1'b1, 1'b0, 8'hD6, 8'h0F);
    op(1'b1, 1'b0, 8'hD2, 8'h40);
    rd(1'b0, 8'hD0, 12'hF40);
    $display("test port cases done");
    @(posedge clock_i);
    #1;
    rst_i = 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    chk("bank", 12'h000, {4'h0, bank_select_reg_o});
    chk("address", 12'h000, ram_addr_o);
    rd(1'b0, 8'hD0, 12'h000);
    rd(1'b1, 8'h34, 12'h034);
    $display("test reset done");
    op(1'b1, 1'b0, 8'hF1, 8'h05);
    chk("flags", 12'h005, {4'h0, alu_flags_o});
    cyc(1'b1, 1'b1, 1'b0, 8'hF1, 8'hFF, 1'b1, ALU_ADD, 8'h01, 8'h01, 1'b0);
    chk("flags", 12'h000, {4'h0, alu_flags_o});
    flg(ALU_ADD, 8'h7F, 8'h01, 8'h1F, 8'h1A);
    flg(ALU_ADD, 8'hFF, 8'h01, 8'h1F, 8'h07);
    flg(ALU_SUB, 8'h05, 8'h05, 8'h1F, 8'h07);
    flg(ALU_SUB, 8'h00, 8'h01, 8'h1F, 8'h10);
    flg(ALU_SUB, 8'h80, 8'h01, 8'h1F, 8'h09);
    flg(ALU_LOGIC, 8'h00, 8'h00, 8'h14, 8'h04);
    flg(ALU_LOGIC, 8'h80, 8'h00, 8'h14, 8'h10);
    flg(ALU_ROTL, 8'h81, 8'h00, 8'h01, 8'h01);
    flg(ALU_ROTR, 8'h80, 8'h00, 8'h01, 8'h00);
    flg(ALU_ROTR, 8'h01, 8'h00, 8'h01, 8'h01);
    $display("test flags done");
    end_of_test();
  end
endmodule
